// file: verilog/regmove_unit.sv
// Register move, index update and bit manipulation unit
`timescale 1ns/1ps
// What this block does
// - copy any register into any other
// - accumulator source sets sticky limit, shift flags
// - shift code never reads 11b
// - master-state register copied into any register
// - any register into master-state, accumulator flags
// - dual transfer: first pair before second
// - refuse dual with two index or modifier sources
// - dual index destinations: groups 0/2 then 1
// - dual modifier destinations: groups 0/2 then 1
// - dual accumulator destinations share index number
// - A bank first pair, B bank second
// - long move: 64 bits through scale, saturate
// - index plus/minus immediate, paired modifier mode
// - zero form uses modifier zero mode
// - updated index ready for next instruction
// - test sets zero when all masked bits one
// - half select; test leaves register unchanged
// - bit operations refuse accumulator targets
// - set: test then OR mask in
// - clear: test then AND inverted mask
// - change: test then XOR mask in
// - decode from low command bits, update flags
module regmove_unit (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [regmove_pkg::AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [regmove_pkg::DW-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [regmove_pkg::DW-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic zero_flag,
    output logic limit_flag,
    output logic shift_code_upper,
    output logic shift_code_lower,
    output logic busy,
    output logic op_error
);
    import regmove_pkg::*;

    state_t st_q;
    logic [1:0] k_q;
    logic [1:0] nwr_q;
    logic pair_q;
    logic pend_q;
    logic idle1_q;
    logic [DW-1:0] cmd_q;
    logic [DW-1:0] opnd_q;
    logic [CW-1:0] widx_q;
    logic [DW-1:0] buf_q [3];
    logic [CW-1:0] wa_q [3];
    logic [DW-1:0] wd_q [3];
    logic [DW-1:0] mem_rdata;
    logic [DW-1:0] mem_wdata;
    logic [CW-1:0] mem_raddr;
    logic [CW-1:0] mem_waddr;
    logic mem_we;
    op_t op;
    logic [CW-1:0] d1, s1, d2, s2, cd, cs;
    logic [15:0] imm;
    logic [1:0] scale;
    logic req, grant, ack, wr_ack, go;
    logic is_bit, is_ix, op_bad, dual_bad;
    logic bad7, bad89, bad10, bad11;
    logic [1:0] nrd;
    logic [CW-1:0] rd_addr;
    logic [31:0] r32;
    logic [63:0] r64;
    logic sat32, sat64;
    logic [DW-1:0] v;
    logic [15:0] ires, half, nh;
    logic [DW-1:0] nw;
    logic use_hi;
    logic acc_ev, bit_ev, err_ev, stat_wr;
    logic [1:0] sh_base;
    logic [DW-1:0] stat;

    function automatic logic in_rng(input logic [CW-1:0] c, lo, n);
        return (c >= lo) && ((c - lo) < n);
    endfunction

    function automatic logic is_full(input logic [CW-1:0] c);
        return in_rng(c, C_ACC, N_ACC);
    endfunction

    function automatic logic is_acc(input logic [CW-1:0] c);
        return in_rng(c, C_ACC, N_ACCALL);
    endfunction

    function automatic logic is_idx(input logic [CW-1:0] c);
        return in_rng(c, C_I, N_IDX);
    endfunction

    function automatic logic is_nm(input logic [CW-1:0] c);
        return in_rng(c, C_NM, N_IDX);
    endfunction

    // Group of four within the index or modifier file
    function automatic logic [1:0] grp(input logic [CW-1:0] c, base);
        logic [CW-1:0] n;
        n = c - base;
        return n[3:2];
    endfunction

    // Storage word of one accumulator segment
    function automatic logic [CW-1:0] acc_word(input logic [CW-1:0] c, base);
        return base + {4'h0, c[2:0]};
    endfunction

    // A full accumulator name points at its high segment
    function automatic logic [CW-1:0] word(input logic [CW-1:0] c);
        return is_full(c) ? acc_word(c, C_ACCH) : c;
    endfunction

    // Trim a value to the destination width
    function automatic logic [DW-1:0] fit(input logic [CW-1:0] c, input logic [DW-1:0] x);
        if (in_rng(c, C_ACCG, N_ACC)) begin
            return {24'h0, x[7:0]};
        end
        if (is_idx(c) || is_nm(c)) begin
            return {16'h0, x[15:0]};
        end
        return x;
    endfunction

    function automatic logic [15:0] rev16(input logic [15:0] x);
        logic [15:0] r;
        for (int i = 0; i < 16; i++) begin
            r[i] = x[15 - i];
        end
        return r;
    endfunction

    // Linear or bit-reversed index arithmetic
    function automatic logic [15:0] idx_add(input logic [15:0] a, b, input logic sub, rv);
        logic [15:0] x, y, r;
        x = rv ? rev16(a) : a;
        y = rv ? rev16(b) : b;
        r = sub ? x - y : x + y;
        return rv ? rev16(r) : r;
    endfunction

    function automatic logic [DW-1:0] be_merge(input logic [DW-1:0] o, n,
                                              input logic [3:0] be);
        logic [DW-1:0] r;
        for (int i = 0; i < 4; i++) begin
            r[8*i +: 8] = be[i] ? n[8*i +: 8] : o[8*i +: 8];
        end
        return r;
    endfunction

    // Command decode, operation from the low four bits
    assign op = op_t'(cmd_q[CMD_OP_LSB +: 4]);
    assign d1 = cmd_q[CMD_D1_LSB +: CW];
    assign s1 = cmd_q[CMD_S1_LSB +: CW];
    assign d2 = opnd_q[OPND_D2_LSB +: CW];
    assign s2 = opnd_q[OPND_S2_LSB +: CW];
    assign imm = opnd_q[OPND_IMM_LSB +: 16];
    assign cd = pair_q ? d2 : d1;
    assign cs = pair_q ? s2 : s1;
    assign scale = (cmd_q[CMD_SC_LSB +: 2] == SC_BAD) ? SC_NONE
                                                      : cmd_q[CMD_SC_LSB +: 2];
    assign is_bit = op inside {OP_TST, OP_SET, OP_CLR, OP_CHG};
    assign is_ix = op inside {OP_IDX, OP_IDX0};

    // Dual transfer operand checks
    assign bad7 = (is_idx(s1) && is_idx(s2)) || (is_nm(s1) && is_nm(s2));
    assign bad89 = (is_idx(d1) && is_idx(d2) && (grp(d1, C_I) == IDX_GRP2
                    || grp(d2, C_I) != IDX_GRP2))
                   || (is_nm(d1) && is_nm(d2) && (grp(d1, C_NM) == IDX_GRP2
                    || grp(d2, C_NM) != IDX_GRP2));
    assign bad10 = is_acc(d1) && is_acc(d2) && (d1[1:0] != d2[1:0]);
    assign bad11 = (is_acc(d1) && d1[2]) || (is_acc(s1) && s1[2])
                   || (is_acc(d2) && !d2[2]) || (is_acc(s2) && !s2[2]);
    assign dual_bad = bad7 || bad89 || bad10 || bad11;

    // Refusal of illegal operands per operation
    always_comb begin
        unique case (op)
            OP_MOVE: op_bad = (d1 >= C_END) || (s1 >= C_END);
            OP_DUAL: op_bad = (d1 >= C_END) || (s1 >= C_END) || (d2 >= C_END)
                              || (s2 >= C_END) || dual_bad;
            OP_LONG: op_bad = !is_full(d1) || !is_full(s1);
            OP_IDX: op_bad = !is_idx(d1) || !is_idx(s1);
            OP_IDX0: op_bad = !is_idx(d1);
            OP_TST, OP_SET, OP_CLR, OP_CHG: op_bad = (d1 >= C_END) || is_acc(d1);
            default: op_bad = 1'b1;
        endcase
    end

    // Read count and address for each read step
    always_comb begin
        nrd = 2'd1;
        rd_addr = cs;
        if (is_bit) begin
            rd_addr = cd;
        end else if (is_ix) begin
            nrd = 2'd2;
            if (k_q != 2'd0) begin
                rd_addr = (op == OP_IDX0) ? C_NM : C_NM + (cs - C_I);
            end
        end else if (is_full(cs)) begin
            nrd = 2'd3;
            rd_addr = (k_q == 2'd0) ? acc_word(cs, C_ACCG)
                    : (k_q == 2'd1) ? acc_word(cs, C_ACCH) : acc_word(cs, C_ACCL);
        end
    end

    srs_stage u_srs (
        .acc({buf_q[0][7:0], buf_q[1], buf_q[2]}),
        .scale(scale),
        .rnd(cmd_q[CMD_RND_BIT]),
        .out32(r32),
        .out64(r64),
        .sat32(sat32),
        .sat64(sat64)
    );

    // Results of the current step
    always_comb begin
        v = is_full(cs) ? r32 : buf_q[0];
        ires = idx_add((op == OP_IDX0) ? 16'h0 : buf_q[0][15:0], imm,
                       cmd_q[CMD_SUB_BIT], buf_q[1][NM_REV_BIT]);
        use_hi = cmd_q[CMD_HI_BIT] && !is_idx(cd) && !is_nm(cd);
        half = use_hi ? buf_q[0][31:16] : buf_q[0][15:0];
        unique case (op)
            OP_SET: nh = half | imm;
            OP_CLR: nh = half & ~imm;
            OP_CHG: nh = half ^ imm;
            default: nh = half;
        endcase
        nw = use_hi ? {nh, buf_q[0][15:0]} : {buf_q[0][31:16], nh};
    end

    // Bus handshake
    assign req = avs_read || avs_write;
    assign grant = !((avs_address == OFS_CMD && avs_write) || avs_address == OFS_WDAT)
                   || (st_q == S_IDLE && idle1_q);
    assign ack = req && pend_q && avs_waitrequest && grant;
    assign wr_ack = req && !avs_waitrequest && avs_write;
    assign go = wr_ack && (avs_address == OFS_CMD);
    assign stat_wr = wr_ack && (avs_address == OFS_STAT) && avs_byteenable[0];

    // Status word
    always_comb begin
        stat = RST_WORD;
        stat[ST_Z] = zero_flag;
        stat[ST_LIM] = limit_flag;
        stat[ST_SHL] = shift_code_lower;
        stat[ST_SHU] = shift_code_upper;
        stat[ST_BUSY] = busy;
        stat[ST_ERR] = op_error;
    end

    // Wait one cycle, command writes and storage data also until idle, then answer with waitrequest low
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= RST_WORD;
            pend_q <= 1'b0;
            idle1_q <= 1'b0;
        end else begin
            idle1_q <= (st_q == S_IDLE);
            if (ack) begin
                avs_waitrequest <= 1'b0;
                pend_q <= 1'b0;
                unique case (avs_address)
                    OFS_CMD: avs_readdata <= cmd_q;
                    OFS_OPND: avs_readdata <= opnd_q;
                    OFS_STAT: avs_readdata <= stat;
                    OFS_WIDX: avs_readdata <= {25'h0, widx_q};
                    OFS_WDAT: avs_readdata <= mem_rdata;
                    default: avs_readdata <= RST_WORD;
                endcase
            end else begin
                avs_waitrequest <= 1'b1;
                pend_q <= req && avs_waitrequest;
            end
        end
    end

    // Software written registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cmd_q <= RST_WORD;
            opnd_q <= RST_WORD;
            widx_q <= RST_IDX;
        end else if (wr_ack) begin
            if (avs_address == OFS_CMD) begin
                cmd_q <= be_merge(cmd_q, avs_writedata, avs_byteenable);
            end
            if (avs_address == OFS_OPND) begin
                opnd_q <= be_merge(opnd_q, avs_writedata, avs_byteenable);
            end
            if (avs_address == OFS_WIDX && avs_byteenable[0]) begin
                widx_q <= avs_writedata[CW-1:0];
            end
        end
    end

    // Storage port sharing: sequencer while busy, bus when idle
    assign mem_raddr = (st_q == S_READ) ? rd_addr : widx_q;
    assign mem_we = (st_q == S_WRITE) || (wr_ack && avs_address == OFS_WDAT);
    assign mem_waddr = (st_q == S_WRITE) ? wa_q[k_q] : widx_q;
    assign mem_wdata = (st_q == S_WRITE) ? wd_q[k_q]
                     : be_merge(mem_rdata, avs_writedata, avs_byteenable);

    reg_store u_store (
        .mclk(mclk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    // Operation sequencer
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_q <= S_IDLE;
            k_q <= 2'd0;
            pair_q <= 1'b0;
            busy <= 1'b0;
        end else begin
            unique case (st_q)
                S_IDLE: if (go) begin
                    st_q <= S_READ;
                    k_q <= 2'd0;
                    pair_q <= 1'b0;
                    busy <= 1'b1;
                end
                S_READ: if (op_bad) begin
                    st_q <= S_IDLE;
                    busy <= 1'b0;
                end else begin
                    st_q <= S_WAIT;
                end
                S_WAIT: if (k_q == nrd - 2'd1) begin
                    k_q <= 2'd0;
                    st_q <= S_CALC;
                end else begin
                    k_q <= k_q + 2'd1;
                    st_q <= S_READ;
                end
                S_CALC: if (op == OP_TST) begin
                    st_q <= S_IDLE;
                    busy <= 1'b0;
                end else begin
                    st_q <= S_WRITE;
                end
                S_WRITE: if (k_q != nwr_q - 2'd1) begin
                    k_q <= k_q + 2'd1;
                end else if (op == OP_DUAL && !pair_q) begin
                    k_q <= 2'd0;
                    pair_q <= 1'b1;
                    st_q <= S_READ;
                end else begin
                    k_q <= 2'd0;
                    st_q <= S_IDLE;
                    busy <= 1'b0;
                end
                default: begin
                    st_q <= S_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    // Read data capture
    always_ff @(posedge mclk) begin
        if (st_q == S_WAIT) begin
            buf_q[k_q] <= mem_rdata;
        end
    end

    // Write list built from the results
    always_ff @(posedge mclk) begin
        if (st_q == S_CALC) begin
            wa_q[0] <= word(cd);
            wd_q[0] <= fit(cd, v);
            nwr_q <= 2'd1;
            wa_q[1] <= acc_word(cd, C_ACCL);
            wa_q[2] <= acc_word(cd, C_ACCG);
            if (op == OP_LONG) begin
                wd_q[0] <= r64[63:32];
                wd_q[1] <= r64[31:0];
                wd_q[2] <= {24'h0, {8{r64[63]}}};
                nwr_q <= 2'd3;
            end else if (is_ix) begin
                wd_q[0] <= {16'h0, ires};
            end else if (is_bit) begin
                wd_q[0] <= nw;
            end else if (is_full(cd)) begin
                wd_q[1] <= RST_WORD;
                wd_q[2] <= {24'h0, {8{v[31]}}};
                nwr_q <= 2'd3;
            end
        end
    end

    // Flag events; a new event beats a clear in the same cycle
    assign acc_ev = (st_q == S_CALC) && is_full(cs) && (op inside {OP_MOVE, OP_DUAL, OP_LONG});
    assign bit_ev = (st_q == S_CALC) && is_bit;
    assign err_ev = (st_q == S_READ) && op_bad;
    assign sh_base = {shift_code_upper, shift_code_lower}
                     & ~({2{stat_wr}} & avs_writedata[ST_SHU:ST_SHL]);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            zero_flag <= 1'b0;
            limit_flag <= 1'b0;
            shift_code_upper <= 1'b0;
            shift_code_lower <= 1'b0;
            op_error <= 1'b0;
        end else begin
            if (bit_ev) begin
                zero_flag <= ((half & imm) ^ imm) == 16'h0;
            end
            limit_flag <= (limit_flag && !(stat_wr && avs_writedata[ST_LIM]))
                          || (acc_ev && (op == OP_LONG ? sat64 : sat32));
            if (acc_ev && sh_base == SC_NONE) begin
                {shift_code_upper, shift_code_lower} <= scale;
            end else begin
                {shift_code_upper, shift_code_lower} <= sh_base;
            end
            op_error <= (op_error && !(stat_wr && avs_writedata[ST_ERR])) || err_ev;
        end
    end
endmodule

// file: inc/regmove_pkg.sv
// Shared constants and types for the register move and bit unit
package regmove_pkg;
    localparam int DW = 32;
    localparam int AW = 8;
    localparam int CW = 7;
    localparam int ACCW = 72;

    // Register byte offsets
    localparam logic [AW-1:0] OFS_CMD = 8'h00;
    localparam logic [AW-1:0] OFS_OPND = 8'h04;
    localparam logic [AW-1:0] OFS_STAT = 8'h08;
    localparam logic [AW-1:0] OFS_WIDX = 8'h0c;
    localparam logic [AW-1:0] OFS_WDAT = 8'h10;

    // Command word fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_HI_BIT = 4;
    localparam int CMD_SC_LSB = 5;
    localparam int CMD_RND_BIT = 7;
    localparam int CMD_D1_LSB = 8;
    localparam int CMD_SUB_BIT = 15;
    localparam int CMD_S1_LSB = 16;

    // Second operand word fields
    localparam int OPND_D2_LSB = 0;
    localparam int OPND_S2_LSB = 8;
    localparam int OPND_IMM_LSB = 16;

    // Status bits
    localparam int ST_Z = 0;
    localparam int ST_LIM = 1;
    localparam int ST_SHL = 2;
    localparam int ST_SHU = 3;
    localparam int ST_BUSY = 4;
    localparam int ST_ERR = 5;

    // Reset values
    localparam logic [DW-1:0] RST_WORD = 32'h0;
    localparam logic [CW-1:0] RST_IDX = 7'h0;

    // Register codes
    localparam logic [CW-1:0] C_X = 7'h00;
    localparam logic [CW-1:0] C_Y = 7'h04;
    localparam logic [CW-1:0] C_ACC = 7'h08;
    localparam logic [CW-1:0] C_ACCL = 7'h10;
    localparam logic [CW-1:0] C_ACCH = 7'h18;
    localparam logic [CW-1:0] C_ACCG = 7'h20;
    localparam logic [CW-1:0] C_I = 7'h28;
    localparam logic [CW-1:0] C_NM = 7'h34;
    localparam logic [CW-1:0] C_MS = 7'h40;
    localparam logic [CW-1:0] C_END = 7'h48;
    localparam logic [CW-1:0] N_ACC = 7'h08;
    localparam logic [CW-1:0] N_ACCALL = 7'h20;
    localparam logic [CW-1:0] N_IDX = 7'h0c;
    localparam logic [1:0] IDX_GRP2 = 2'b01;
    localparam int NM_REV_BIT = 15;

    // Scale modes, equal to the shift code they report
    localparam logic [1:0] SC_NONE = 2'b00;
    localparam logic [1:0] SC_LEFT = 2'b01;
    localparam logic [1:0] SC_RIGHT = 2'b10;
    localparam logic [1:0] SC_BAD = 2'b11;
    localparam logic [ACCW:0] RND_HALF = 73'h0_0000_0000_8000_0000;

    typedef enum logic [3:0] {
        OP_MOVE = 4'h0,
        OP_DUAL = 4'h1,
        OP_LONG = 4'h2,
        OP_IDX = 4'h3,
        OP_IDX0 = 4'h4,
        OP_TST = 4'h5,
        OP_SET = 4'h6,
        OP_CLR = 4'h7,
        OP_CHG = 4'h8
    } op_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_READ = 3'b001,
        S_WAIT = 3'b010,
        S_CALC = 3'b011,
        S_WRITE = 3'b100
    } state_t;
endpackage

// file: verilog/reg_store.sv
// Core register storage, one write port and a registered read port
`timescale 1ns/1ps
module reg_store (
    input wire logic mclk,
    input wire logic we,
    input wire logic [regmove_pkg::CW-1:0] waddr,
    input wire logic [regmove_pkg::DW-1:0] wdata,
    input wire logic [regmove_pkg::CW-1:0] raddr,
    output logic [regmove_pkg::DW-1:0] rdata
);
    import regmove_pkg::*;

    logic [DW-1:0] mem [2**CW];

    // Write port
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read
    always_ff @(posedge mclk) begin
        rdata <= mem[raddr];
    end
endmodule

// file: verilog/srs_stage.sv
// Shift, round and saturate stage for accumulator sources
`timescale 1ns/1ps
module srs_stage (
    input wire logic [regmove_pkg::ACCW-1:0] acc,
    input wire logic [1:0] scale,
    input wire logic rnd,
    output logic [31:0] out32,
    output logic [63:0] out64,
    output logic sat32,
    output logic sat64
);
    import regmove_pkg::*;

    logic [ACCW:0] shf;
    logic [ACCW:0] rv;

    // True when the value does not fit 64 signed bits
    function automatic logic ovf(input logic [ACCW:0] x);
        return !((&x[ACCW:63]) || !(|x[ACCW:63]));
    endfunction

    // Scale then optional round at the 32-bit boundary
    always_comb begin
        unique case (scale)
            SC_LEFT: shf = {acc, 1'b0};
            SC_RIGHT: shf = {acc[ACCW-1], acc[ACCW-1], acc[ACCW-1:1]};
            default: shf = {acc[ACCW-1], acc};
        endcase
        rv = rnd ? shf + RND_HALF : shf;
    end

    // Saturated outputs
    always_comb begin
        sat32 = ovf(rv);
        sat64 = ovf(shf);
        out32 = rv[63:32];
        out64 = shf[63:0];
        if (sat32) begin
            out32 = rv[ACCW] ? 32'h8000_0000 : 32'h7fff_ffff;
        end
        if (sat64) begin
            out64 = shf[ACCW] ? 64'h8000_0000_0000_0000 : 64'h7fff_ffff_ffff_ffff;
        end
    end
endmodule

// file: test/regmove_unit_asserts.sv
// Port assertions for the register move and bit unit
`timescale 1ns/1ps
module regmove_chk (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [regmove_pkg::AW-1:0] avs_address,
    input wire logic avs_write,
    input wire logic [regmove_pkg::DW-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic zero_flag,
    input wire logic limit_flag,
    input wire logic shift_code_upper,
    input wire logic shift_code_lower,
    input wire logic busy,
    input wire logic op_error
);
    import regmove_pkg::*;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    // Accepted writes
    logic hit, cmd_hit;
    logic [3:0] clr;
    assign hit = avs_write && !avs_waitrequest;
    assign cmd_hit = hit && avs_address == OFS_CMD;
    assign clr = {4{hit && avs_address == OFS_STAT && avs_byteenable[0]}} & avs_writedata[3:0];
    // Held level
    sequence s_hold(f, c);
        f && !c;
    endsequence
    AST_SHIFT_NOT_11: assert property (!(shift_code_upper && shift_code_lower))
        else $error("shift code 11");
    AST_LIM_STICKY: assert property (s_hold(limit_flag, clr[ST_LIM]) |=> limit_flag)
        else $error("limit lost");
    AST_SHL_STICKY: assert property (s_hold(shift_code_lower, clr[ST_SHL])
        |=> shift_code_lower) else $error("shift lower lost");
    AST_SHU_STICKY: assert property (s_hold(shift_code_upper, clr[ST_SHU])
        |=> shift_code_upper) else $error("shift upper lost");
    AST_FLAG_BY_OP: assert property ($rose(limit_flag) || $rose(shift_code_lower)
        || $rose(shift_code_upper) |-> $past(busy)) else $error("flag set while idle");
    AST_ZERO_BY_OP: assert property ($changed(zero_flag) |-> $past(busy))
        else $error("zero changed while idle");
    AST_ERR_BY_CMD: assert property ($rose(op_error) |-> $past(busy) || $past(avs_write))
        else $error("error without command");
    AST_BUSY_FROM_CMD: assert property (s_hold(!busy, cmd_hit) |=> !busy)
        else $error("busy without command");
    AST_OP_BOUNDED: assert property ($rose(busy) |-> ##[1:60] !busy)
        else $error("operation hung");
endmodule
bind regmove_unit regmove_chk chk (.*);

// file: test/test_regmove_unit.sv
// Self-checking bench for the register move and bit unit
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module test_regmove_unit;
    import regmove_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [AW-1:0] avs_address = 8'h0;
    logic [DW-1:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [DW-1:0] avs_readdata, rv, m;
    logic avs_waitrequest, zero_flag, limit_flag, shift_code_upper, shift_code_lower;
    logic busy, op_error, z;
    logic [15:0] h;
    int err_total = 0;
    int total_checks = 0;
    // Refused operands; bit operation table
    op_t bo[9] = '{OP_DUAL, OP_DUAL, OP_DUAL, OP_DUAL, OP_DUAL, OP_DUAL, OP_TST, OP_LONG, OP_IDX};
    logic [6:0] d1[9] = '{7'h02, 7'h02, C_I + 7'h4, C_NM, C_ACC, C_ACC + 7'h4, C_ACC,
        C_ACC + 7'h1, C_X};
    logic [6:0] s1[9] = '{C_I, C_NM, C_X, C_X, C_X, C_X, C_X, C_X, C_X};
    logic [6:0] d2[9] = '{7'h03, 7'h03, C_I + 7'h5, C_NM + 7'h8, C_ACC + 7'h5, C_ACC, C_X, C_X,
        C_X};
    logic [6:0] s2[9] = '{C_I + 7'h4, C_NM + 7'h4, C_X, C_X, C_X, C_X, C_X, C_X, C_X};
    op_t bt[4] = '{OP_TST, OP_SET, OP_CLR, OP_CHG};
    logic bh[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    logic [15:0] bk[4] = '{16'h00a5, 16'hf000, 16'h0005, 16'h00ff};

    regmove_unit DUT (.*);

    // Clock
    always #50 mclk = ~mclk;

    // One bus access, held until accepted
    task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rv = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask

    // Register storage load and fetch
    task automatic ld(input logic [6:0] r, input logic [31:0] v);
        acc(OFS_WIDX, 1'b1, {25'h0, r});
        acc(OFS_WDAT, 1'b1, v);
    endtask
    task automatic get(input logic [6:0] r);
        acc(OFS_WIDX, 1'b1, {25'h0, r});
        acc(OFS_WDAT, 1'b0, 32'h0);
    endtask

    // Command word builder
    function automatic logic [31:0] mk(input op_t op, input logic hi, input logic [1:0] sc,
        input logic [6:0] d, input logic [6:0] s, input logic sub);
        return {9'h0, s, sub, d, 1'b0, sc, hi, op};
    endfunction

    // Start an operation, await its end
    task automatic run(input logic [31:0] c, input logic [31:0] o);
        acc(OFS_OPND, 1'b1, o);
        acc(OFS_CMD, 1'b1, c);
        for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge mclk);
    endtask

    task automatic summarize();
        if (err_total == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        summarize();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
        acc(OFS_STAT, 1'b0, 32'h0);
        `CHK(rv, 32'h0)
        acc(8'h40, 1'b0, 32'h0);
        `CHK(rv, 32'h0)
        ld(C_X, 32'h1234_5678);
        ld(C_X + 7'h1, 32'hcafe_0001);
        run(mk(OP_MOVE, 1'b0, SC_NONE, C_Y + 7'h1, C_X, 1'b0), 32'h0);
        get(C_Y + 7'h1);
        `CHK(rv, 32'h1234_5678)
        run(mk(OP_MOVE, 1'b0, SC_NONE, C_MS, C_X + 7'h1, 1'b0), 32'h0);
        run(mk(OP_MOVE, 1'b0, SC_NONE, C_Y, C_MS, 1'b0), 32'h0);
        get(C_Y);
        `CHK(rv, 32'hcafe_0001)
        // Same destination: second pair lands last
        run(mk(OP_DUAL, 1'b0, SC_NONE, 7'h03, C_X, 1'b0), {17'h0, C_X + 7'h1, 1'b0, 7'h03});
        get(7'h03);
        `CHK(rv, 32'hcafe_0001)
        run(mk(OP_DUAL, 1'b0, SC_NONE, C_I, C_X, 1'b0), {17'h0, C_X + 7'h1, 1'b0, C_I + 7'h4});
        `CHK(op_error, 1'b0)
        get(C_I + 7'h4);
        `CHK(rv[15:0], 16'h0001)
        for (int i = 0; i < 9; i++) begin
            run(mk(bo[i], 1'b0, SC_NONE, d1[i], s1[i], 1'b0), {17'h0, s2[i], 1'b0, d2[i]});
            `CHK(op_error, 1'b1)
            acc(OFS_STAT, 1'b1, 32'h20);
            `CHK(op_error, 1'b0)
        end
        // Index arithmetic
        ld(C_NM, 32'h0);
        ld(C_NM + 7'h2, 32'h0);
        ld(C_NM + 7'h5, 32'h8000);
        ld(C_I + 7'h2, 32'h10);
        run(mk(OP_IDX, 1'b0, SC_NONE, C_I + 7'h3, C_I + 7'h2, 1'b0), 32'h0100_0000);
        get(C_I + 7'h3);
        `CHK(rv[15:0], 16'h0110)
        run(mk(OP_IDX, 1'b0, SC_NONE, C_I + 7'h3, C_I + 7'h2, 1'b1), 32'h0020_0000);
        get(C_I + 7'h3);
        `CHK(rv[15:0], 16'hfff0)
        run(mk(OP_IDX0, 1'b0, SC_NONE, C_I + 7'h5, C_I, 1'b1), 32'h0001_0000);
        get(C_I + 7'h5);
        `CHK(rv[15:0], 16'hffff)
        // Bit operations vs model
        m = 32'h0f0f_a5a5;
        ld(C_X + 7'h2, m);
        for (int i = 0; i < 4; i++) begin
            h = bh[i] ? m[31:16] : m[15:0];
            z = ((h & bk[i]) ^ bk[i]) == 16'h0;
            h = bt[i] == OP_SET ? h | bk[i] : bt[i] == OP_CLR ? h & ~bk[i] :
                bt[i] == OP_CHG ? h ^ bk[i] : h;
            m = bh[i] ? {h, m[15:0]} : {m[31:16], h};
            run(mk(bt[i], bh[i], SC_NONE, C_X + 7'h2, C_X, 1'b0), {bk[i], 16'h0});
            `CHK(zero_flag, z)
            get(C_X + 7'h2);
            `CHK(rv, m)
        end
        // Accumulator source flags
        ld(C_ACCG, 32'h01);
        ld(C_ACCH, 32'h0);
        ld(C_ACCL, 32'h0);
        run(mk(OP_MOVE, 1'b0, SC_LEFT, C_X, C_ACC, 1'b0), 32'h0);
        `CHK({limit_flag, shift_code_upper, shift_code_lower}, 3'b101)
        run(mk(OP_MOVE, 1'b0, SC_RIGHT, C_X, C_ACC, 1'b0), 32'h0);
        `CHK({shift_code_upper, shift_code_lower}, SC_LEFT)
        acc(OFS_STAT, 1'b1, 32'he);
        `CHK({limit_flag, shift_code_upper, shift_code_lower}, 3'b000)
        run(mk(OP_LONG, 1'b0, SC_BAD, C_ACC + 7'h1, C_ACC, 1'b0), 32'h0);
        `CHK({limit_flag, shift_code_upper, shift_code_lower}, 3'b100)
        run(mk(OP_MOVE, 1'b0, SC_RIGHT, C_MS, C_ACC, 1'b0), 32'h0);
        `CHK({shift_code_upper, shift_code_lower}, SC_RIGHT)
        summarize();
    end
endmodule
